// File: shrb_consts.vh
// constants for the serial host receive buffer block
// assumes a 10 MHz system clock and an ahb-lite register bus
// Functional notes
// - six selectable baud rates, both directions shared
// - 7/8 data bits, even/odd/no parity, one stop
// - queue all but immediate commands, 11 Kbyte
// - parity error stores '@', framing stores '~'
// - jam stops queue draining, shows jam message
// - next status byte carries jam flag
// - DC4 primary or CAN alternate flushes queue
// - clear key flushes after removal, head left
// - flow control by DTR or XON/XOFF
// - CR/movement with under 1000 free pauses host
// - space back: raise DTR or send DC1
// - status sent only while CTS asserted
// - DTR shows ready, plus room in DTR mode
// - TXD carries responses, RXD takes host data
// - status byte 0,1,doc,err,jam,key,busy,room
// - room flag: 1000 free or queue empty
`ifndef SHRB_CONSTS_VH
`define SHRB_CONSTS_VH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SHRB_CLK_HZ        10000000
`define SHRB_OVERSAMPLE    16
`define SHRB_DIV_1200      (`SHRB_CLK_HZ / (`SHRB_OVERSAMPLE * 1200))
`define SHRB_DIV_2400      (`SHRB_CLK_HZ / (`SHRB_OVERSAMPLE * 2400))
`define SHRB_DIV_4800      (`SHRB_CLK_HZ / (`SHRB_OVERSAMPLE * 4800))
`define SHRB_DIV_9600      (`SHRB_CLK_HZ / (`SHRB_OVERSAMPLE * 9600))
`define SHRB_DIV_19200     (`SHRB_CLK_HZ / (`SHRB_OVERSAMPLE * 19200))
`define SHRB_DIV_38400     (`SHRB_CLK_HZ / (`SHRB_OVERSAMPLE * 38400))

// ------------------------------------------------------------
// queue
// ------------------------------------------------------------
`define SHRB_DEPTH         14'h2C00
`define SHRB_ROOM_MIN      14'h03E8

// ------------------------------------------------------------
// characters
// ------------------------------------------------------------
`define SHRB_CH_ENQ        8'h05
`define SHRB_CH_LF         8'h0A
`define SHRB_CH_FF         8'h0C
`define SHRB_CH_CR         8'h0D
`define SHRB_CH_DC1        8'h11
`define SHRB_CH_DC3        8'h13
`define SHRB_CH_DC4        8'h14
`define SHRB_CH_CAN        8'h18
`define SHRB_CH_PERR       8'h40
`define SHRB_CH_FERR       8'h7E

// ------------------------------------------------------------
// registers: byte offsets, fields, reset values
// ------------------------------------------------------------
`define SHRB_OFS_CFG       6'h00
`define SHRB_OFS_CTRL      6'h04
`define SHRB_OFS_CMD       6'h08
`define SHRB_OFS_STATUS    6'h0C
`define SHRB_OFS_LEVEL     6'h10
`define SHRB_OFS_DATA      6'h14
`define SHRB_CFG_BAUD_LSB  0
`define SHRB_CFG_BAUD_MSB  2
`define SHRB_CFG_EIGHT     3
`define SHRB_CFG_PAR_LSB   4
`define SHRB_CFG_PAR_MSB   5
`define SHRB_CFG_XON       6
`define SHRB_CFG_ALT       7
`define SHRB_CFG_READY     8
`define SHRB_CFG_RESET     9'h10D
`define SHRB_CTRL_DOC      0
`define SHRB_CTRL_KEY      1
`define SHRB_CTRL_BUSY     2
`define SHRB_CTRL_LEFT     3
`define SHRB_CTRL_RESET    4'h0
`define SHRB_CMD_JAM_SET   0
`define SHRB_CMD_JAM_CLR   1
`define SHRB_CMD_CLEAR_KEY 2
`define SHRB_CMD_STATUS    3
`define SHRB_PAR_EVEN      2'h1
`define SHRB_PAR_ODD       2'h2

`endif

// File: shrb_host_model.sv
// host serial port model
// assumes 38400 baud, 8N1 frames toward the host
`timescale 1ns/1ps
`include "shrb_consts.vh"
module shrb_host_model #(
    parameter int BIT = 16 * `SHRB_DIV_38400
) (
    input  wire logic i_clk,
    input  wire logic i_txd,
    input  wire logic i_dtr,
    output logic      o_rxd
);
    logic [7:0] rq[$];
    logic       paused = 1'b0;
    initial o_rxd = 1'b1;
    task automatic put_bit(input logic b);
        o_rxd <= b;
        repeat (BIT) @(posedge i_clk);
    endtask
    // bad: 1 parity wrong, 2 stop bit low
    task automatic send(input logic [7:0] ch, input int nb, input int par, input int bad);
        logic p;
        p = (^ch[6:0]) ^ (nb == 8 && ch[7]) ^ (par == 2) ^ (bad == 1);
        while (paused || !i_dtr) @(posedge i_clk);
        @(posedge i_clk);
        put_bit(1'b0);
        for (int i = 0; i < nb; i++)
            put_bit(ch[i]);
        if (par != 0)
            put_bit(p);
        put_bit(bad != 2);
        o_rxd <= 1'b1;
    endtask
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge i_txd);
            repeat (BIT / 2) @(negedge i_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(negedge i_clk);
                b[i] = i_txd;
            end
            repeat (BIT) @(negedge i_clk);
            rq.push_back(b);
            if (b == `SHRB_CH_DC3) paused = 1'b1;
            if (b == `SHRB_CH_DC1) paused = 1'b0;
        end
    end
endmodule

// File: shrb_mem.v
// single-port-write, registered-read byte memory for the input queue
// assumes one clock; read data follows the read address by one edge
`timescale 1ns/1ps
module shrb_mem (
    input  wire        i_sys_clk,
    input  wire        i_we,
    input  wire [13:0] i_waddr,
    input  wire [7:0]  i_wdata,
    input  wire [13:0] i_raddr,
    output reg  [7:0]  o_rdata
);
    reg [7:0] mem [0:11263];

    always @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// File: shrb_tb_top.sv
// self-checking bench, ahb master and host model
// assumes checker and host model compiled first
`timescale 1ns/1ps
`include "shrb_consts.vh"
module shrb_tb_top;
    logic        clk, rst, hsel, hwrite, cts, lerr, jmf;
    logic [31:0] haddr, hwdata, rd, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  mq[$];
    wire  [31:0] hrdata;
    wire         hready, hresp, txd, rxd, dtr, jam;
    int          n_fail, n_tests;
    localparam logic [31:0] CFG0 = {23'h000000, `SHRB_CFG_RESET};
    shrb_top dut (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_rxd(rxd), .o_txd(txd),
        .i_cts(cts), .o_dtr(dtr), .o_jam_msg(jam)
    );
    shrb_host_model host (.i_clk(clk), .i_txd(txd), .i_dtr(dtr), .o_rxd(rxd));
    // ----
    // tasks
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] stat();
        return {24'h000000, 2'h1, 1'b0, lerr, jmf, 2'h0, 1'b1};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        logic ok;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {26'h0000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(negedge clk);
            ok = hready;
            @(posedge clk);
        end while (ok !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge clk);
            ok = hready;
            rd = hrdata;
            @(posedge clk);
        end while (ok !== 1'b1);
        @(negedge clk);
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(nm, rd, exp);
    endtask
    task automatic put(input logic [7:0] ch, input int nb, input int par, input int bad);
        host.send(ch, nb, par, bad);
        repeat (4) @(posedge clk);
        lerr |= (bad != 0);
        mq.push_back(bad == 1 ? `SHRB_CH_PERR : bad == 2 ? `SHRB_CH_FERR :
                     ch & (nb == 8 ? 8'hFF : 8'h7F));
    endtask
    task automatic drain();
        rchk("level", `SHRB_OFS_LEVEL, 32'(mq.size()));
        while (mq.size() > 0) begin
            bus(1'b0, `SHRB_OFS_DATA, 32'h00000000);
            chk("data", rd, {23'h000000, 1'b1, mq.pop_front()});
        end
    endtask
    task automatic flush(input logic [7:0] ch);
        host.send(ch, 8, 0, 0);
        repeat (4) @(posedge clk);
        mq.delete();
        rchk("flush", `SHRB_OFS_LEVEL, 32'h00000000);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        {hsel, hwrite, cts, lerr, jmf, htrans, haddr, hwdata} = 71'h0;
        hsize = 3'h2;
        rst = 1'b1;
        seed = 32'h0000795F;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rchk("cfg", `SHRB_OFS_CFG, CFG0);
        rchk("unmapped", 6'h3C, 32'h00000000);
        bus(1'b1, `SHRB_OFS_LEVEL, 32'h00000007);
        chk("dtr", dtr, 1'b1);
        chk("hresp", hresp, 1'b0);
        bus(1'b1, `SHRB_OFS_CFG, CFG0 & 32'hFFFFFEFF);
        chk("dtr off", dtr, 1'b0);
        bus(1'b1, `SHRB_OFS_CFG, CFG0 | 32'h00000040);
        chk("dtr xon", dtr, 1'b1);
        bus(1'b1, `SHRB_OFS_CFG, CFG0);
        $display("reset test done");
        repeat (4) begin
            r = rnd();
            put(8'h20 + {2'h0, r[5:0]}, 8, 0, 0);
        end
        drain();
        for (int p = 1; p <= 2; p++) begin
            bus(1'b1, `SHRB_OFS_CFG, CFG0 | (32'(p) << 4));
            put(8'h35, 8, p, 0);
            put(8'h36, 8, p, 1);
        end
        bus(1'b1, `SHRB_OFS_CFG, CFG0 & 32'hFFFFFFF7);
        put(8'h55, 7, 0, 0);
        bus(1'b1, `SHRB_OFS_CFG, CFG0);
        put(8'h37, 8, 0, 2);
        drain();
        $display("error test done");
        put(8'h41, 8, 0, 0);
        bus(1'b1, `SHRB_OFS_CMD, 32'h00000001);
        jmf = 1'b1;
        chk("jam", jam, jmf);
        bus(1'b0, `SHRB_OFS_DATA, 32'h00000000);
        chk("pop in jam", rd[8], 1'b0);
        rchk("status reg", `SHRB_OFS_STATUS, stat());
        host.send(`SHRB_CH_ENQ, 8, 0, 0);
        repeat (12 * host.BIT) @(posedge clk);
        chk("cts gate", 32'(host.rq.size()), 32'h00000000);
        cts <= 1'b1;
        for (int i = 0; i < 4000 && host.rq.size() == 0; i++) @(posedge clk);
        chk("status tx", host.rq.pop_front(), stat());
        lerr = 1'b0;
        bus(1'b1, `SHRB_OFS_CMD, 32'h00000002);
        jmf = 1'b0;
        chk("jam clr", jam, jmf);
        drain();
        $display("jam test done");
        put(8'h42, 8, 0, 0);
        flush(`SHRB_CH_DC4);
        bus(1'b1, `SHRB_OFS_CFG, CFG0 | 32'h00000080);
        put(8'h43, 8, 0, 0);
        flush(`SHRB_CH_CAN);
        put(8'h44, 8, 0, 0);
        bus(1'b1, `SHRB_OFS_CTRL, 32'h00000009);
        bus(1'b1, `SHRB_OFS_CMD, 32'h00000004);
        rchk("key doc in", `SHRB_OFS_LEVEL, 32'h00000001);
        bus(1'b1, `SHRB_OFS_CTRL, 32'h00000008);
        bus(1'b1, `SHRB_OFS_CMD, 32'h00000004);
        rchk("key flush", `SHRB_OFS_LEVEL, 32'h00000000);
        $display("flush test done");
        close_out();
    end
endmodule

// File: shrb_top.v
// serial host receive front end with input queue and flow control
// assumes ahb-lite master on the register side, rs-232 levels converted outside
`timescale 1ns/1ps
`include "shrb_consts.vh"
module shrb_top (
    input  wire        i_sys_clk,
    input  wire        i_sys_rst,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output wire        o_hreadyout,
    output wire        o_hresp,
    input  wire        i_rxd,
    output reg         o_txd,
    input  wire        i_cts,
    output wire        o_dtr,
    output wire        o_jam_msg
);
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_START = 5'h02;
    localparam [4:0] ST_DATA  = 5'h04;
    localparam [4:0] ST_PAR   = 5'h08;
    localparam [4:0] ST_STOP  = 5'h10;

    reg  [8:0]  cfg;
    reg  [3:0]  ctrl;
    reg         jam_flag;
    reg         line_error_flag;
    reg  [13:0] count;
    reg  [13:0] wr_ptr;
    reg  [13:0] rd_ptr;
    reg         stopped;
    reg         xoff_pend;
    reg         xon_pend;
    reg         stat_pend;
    wire [7:0]  mem_q;

    wire        eight    = cfg[`SHRB_CFG_EIGHT];
    wire [1:0]  par_mode = cfg[`SHRB_CFG_PAR_MSB:`SHRB_CFG_PAR_LSB];
    wire        par_en   = (par_mode == `SHRB_PAR_EVEN) || (par_mode == `SHRB_PAR_ODD);
    wire        par_odd  = (par_mode == `SHRB_PAR_ODD);
    wire        xon_mode = cfg[`SHRB_CFG_XON];
    wire        doc_present_flag = ctrl[`SHRB_CTRL_DOC];
    wire        key_pending_flag = ctrl[`SHRB_CTRL_KEY];
    wire        busy_flag        = ctrl[`SHRB_CTRL_BUSY];
    wire [13:0] free_space = `SHRB_DEPTH - count;
    wire        room_flag  = (free_space >= `SHRB_ROOM_MIN) || (count == 14'h0000);
    wire [7:0]  status_byte = {1'b0, 1'b1, doc_present_flag, line_error_flag,
                               jam_flag, key_pending_flag, busy_flag, room_flag};

    // ------------------------------------------------------------
    // baud rate divider, 16x enable
    // ------------------------------------------------------------
    function [9:0] div_sel;
        input [2:0] s;
        reg [31:0] v;
        begin
            case (s)
                3'h0:    v = `SHRB_DIV_1200;
                3'h1:    v = `SHRB_DIV_2400;
                3'h2:    v = `SHRB_DIV_4800;
                3'h3:    v = `SHRB_DIV_9600;
                3'h4:    v = `SHRB_DIV_19200;
                default: v = `SHRB_DIV_38400;
            endcase
            div_sel = v[9:0];
        end
    endfunction

    reg  [9:0] div_cnt;
    wire [9:0] div_val = div_sel(cfg[`SHRB_CFG_BAUD_MSB:`SHRB_CFG_BAUD_LSB]);
    wire       tick    = (div_cnt >= div_val - 10'h001);

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            div_cnt <= 10'h000;
        end else if (tick) begin
            div_cnt <= 10'h000;
        end else begin
            div_cnt <= div_cnt + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    reg  [4:0] rx_st;
    reg  [3:0] rx_tick;
    reg  [2:0] rx_bit;
    reg  [7:0] rx_sh;
    reg        rx_perr;
    reg        rx_done;
    reg        rx_ferr;
    wire [7:0] rx_char = eight ? rx_sh : {1'b0, rx_sh[7:1]};
    wire [2:0] rx_last = eight ? 3'h7 : 3'h6;

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rx_st   <= ST_IDLE;
            rx_tick <= 4'h0;
            rx_bit  <= 3'h0;
            rx_sh   <= 8'h00;
            rx_perr <= 1'b0;
            rx_done <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                case (rx_st)
                    ST_IDLE: begin
                        rx_tick <= 4'h0;
                        if (!i_rxd) begin
                            rx_st <= ST_START;
                        end
                    end
                    ST_START: begin
                        rx_perr <= 1'b0;
                        if (rx_tick == 4'h7) begin
                            rx_tick <= 4'h0;
                            rx_bit  <= 3'h0;
                            rx_st   <= i_rxd ? ST_IDLE : ST_DATA;
                        end else begin
                            rx_tick <= rx_tick + 4'h1;
                        end
                    end
                    ST_DATA: begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == 4'hF) begin
                            rx_sh  <= {i_rxd, rx_sh[7:1]};
                            rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == rx_last) begin
                                rx_st <= par_en ? ST_PAR : ST_STOP;
                            end
                        end
                    end
                    ST_PAR: begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == 4'hF) begin
                            rx_perr <= (i_rxd != ((^rx_char) ^ par_odd));
                            rx_st   <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == 4'hF) begin
                            rx_done <= 1'b1;
                            rx_ferr <= !i_rxd;
                            rx_st   <= ST_IDLE;
                        end
                    end
                    default: rx_st <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // character sorting
    // ------------------------------------------------------------
    wire       rx_err   = rx_ferr || rx_perr;
    wire       is_enq   = !rx_err && (rx_char == `SHRB_CH_ENQ);
    wire       is_flush = !rx_err && (cfg[`SHRB_CFG_ALT] ? (rx_char == `SHRB_CH_CAN)
                                                         : (rx_char == `SHRB_CH_DC4));
    wire       is_move  = !rx_err && ((rx_char == `SHRB_CH_CR) || (rx_char == `SHRB_CH_LF) ||
                                      (rx_char == `SHRB_CH_FF));
    wire [7:0] q_char   = rx_ferr ? `SHRB_CH_FERR : (rx_perr ? `SHRB_CH_PERR : rx_char);
    wire       q_write  = rx_done && !is_enq && !is_flush && (count != `SHRB_DEPTH);

    reg  [4:0] tx_st;
    reg  [3:0] tx_tick;
    reg  [2:0] tx_bit;
    reg  [7:0] tx_sh;
    reg        tx_par;
    wire       tx_idle    = (tx_st == ST_IDLE);
    wire       tx_is_xoff = xoff_pend;
    wire       tx_is_xon  = !xoff_pend && xon_pend;
    wire       tx_want_st = !xoff_pend && !xon_pend && stat_pend && i_cts;
    wire       tx_load    = tx_idle && tick && (xoff_pend || xon_pend || tx_want_st);
    wire       tx_load_stat = tx_load && tx_want_st;
    wire [7:0] tx_byte    = tx_is_xoff ? `SHRB_CH_DC3 : (tx_is_xon ? `SHRB_CH_DC1 : status_byte);
    wire [7:0] tx_bits    = eight ? tx_byte : {1'b0, tx_byte[6:0]};
    wire       o_txd_busy = !tx_idle;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    reg        dp_write;
    reg  [5:0] dp_addr;
    reg  [1:0] rd_stage;
    reg        pop_valid;
    wire       accept  = i_hsel && i_htrans[1] && i_hready;
    wire [5:0] a_addr  = i_haddr[5:0];
    wire       cmd_wr  = dp_write && (dp_addr == `SHRB_OFS_CMD);
    wire       jam_set = cmd_wr && i_hwdata[`SHRB_CMD_JAM_SET];
    wire       jam_clr = cmd_wr && i_hwdata[`SHRB_CMD_JAM_CLR];
    wire       key_clr = cmd_wr && i_hwdata[`SHRB_CMD_CLEAR_KEY] && !doc_present_flag &&
                         ctrl[`SHRB_CTRL_LEFT];
    wire       sw_stat = cmd_wr && i_hwdata[`SHRB_CMD_STATUS];
    wire       flush   = (rx_done && is_flush) || key_clr;
    wire       pop     = (rd_stage == 2'h2) && pop_valid && !flush;

    assign o_hreadyout = (rd_stage == 2'h0);
    assign o_hresp     = 1'b0;

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            dp_write  <= 1'b0;
            dp_addr   <= 6'h00;
            rd_stage  <= 2'h0;
            pop_valid <= 1'b0;
            o_hrdata  <= 32'h00000000;
            cfg       <= `SHRB_CFG_RESET;
            ctrl      <= `SHRB_CTRL_RESET;
        end else begin
            if (dp_write && (dp_addr == `SHRB_OFS_CFG)) begin
                cfg <= i_hwdata[8:0];
            end
            if (dp_write && (dp_addr == `SHRB_OFS_CTRL)) begin
                ctrl <= i_hwdata[3:0];
            end
            if (o_hreadyout) begin
                dp_write <= accept && i_hwrite;
                dp_addr  <= a_addr;
            end
            if (rd_stage == 2'h1) begin
                rd_stage  <= 2'h2;
                pop_valid <= (count != 14'h0000) && !jam_flag;
            end else if (rd_stage == 2'h2) begin
                rd_stage <= 2'h0;
                o_hrdata <= {23'h000000, pop_valid, pop_valid ? mem_q : 8'h00};
            end else if (accept && !i_hwrite) begin
                case (a_addr)
                    `SHRB_OFS_CFG:    o_hrdata <= {23'h000000, cfg};
                    `SHRB_OFS_CTRL:   o_hrdata <= {28'h0000000, ctrl};
                    `SHRB_OFS_STATUS: o_hrdata <= {22'h000000, o_txd_busy, stopped, status_byte};
                    `SHRB_OFS_LEVEL:  o_hrdata <= {18'h00000, count};
                    `SHRB_OFS_DATA: begin
                        rd_stage <= 2'h1;
                        o_hrdata <= 32'h00000000;
                    end
                    default:          o_hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // input queue and occupancy
    // ------------------------------------------------------------
    shrb_mem u_mem (
        .i_sys_clk (i_sys_clk),
        .i_we      (q_write),
        .i_waddr   (wr_ptr),
        .i_wdata   (q_char),
        .i_raddr   (rd_ptr),
        .o_rdata   (mem_q)
    );

    wire [13:0] last_idx = `SHRB_DEPTH - 14'h0001;

    always @(posedge i_sys_clk) begin
        if (i_sys_rst || flush) begin
            wr_ptr <= 14'h0000;
            rd_ptr <= 14'h0000;
            count  <= 14'h0000;
        end else begin
            if (q_write) begin
                wr_ptr <= (wr_ptr == last_idx) ? 14'h0000 : wr_ptr + 14'h0001;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == last_idx) ? 14'h0000 : rd_ptr + 14'h0001;
            end
            if (q_write && !pop) begin
                count <= count + 14'h0001;
            end else if (pop && !q_write) begin
                count <= count - 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // flags and flow control
    // ------------------------------------------------------------
    wire room_back = free_space >= `SHRB_ROOM_MIN;
    wire go_stop   = rx_done && is_move && !room_back && !stopped;
    wire go_run    = stopped && room_back;

    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            jam_flag        <= 1'b0;
            line_error_flag <= 1'b0;
            stopped         <= 1'b0;
            xoff_pend       <= 1'b0;
            xon_pend        <= 1'b0;
            stat_pend       <= 1'b0;
        end else begin
            jam_flag        <= jam_set || (jam_flag && !jam_clr);
            line_error_flag <= (rx_done && rx_err) || (line_error_flag && !tx_load_stat);
            stat_pend       <= (rx_done && is_enq) || sw_stat || (stat_pend && !tx_load_stat);
            if (go_stop) begin
                stopped <= 1'b1;
            end else if (go_run) begin
                stopped <= 1'b0;
            end
            xoff_pend <= (go_stop && xon_mode) || (xoff_pend && !(tx_load && tx_is_xoff));
            xon_pend  <= (go_run && xon_mode) || (xon_pend && !(tx_load && tx_is_xon));
        end
    end

    assign o_dtr     = cfg[`SHRB_CFG_READY] && (xon_mode || !stopped);
    assign o_jam_msg = jam_flag;

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            tx_st   <= ST_IDLE;
            tx_tick <= 4'h0;
            tx_bit  <= 3'h0;
            tx_sh   <= 8'h00;
            tx_par  <= 1'b0;
            o_txd   <= 1'b1;
        end else if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            case (tx_st)
                ST_IDLE: begin
                    tx_tick <= 4'h0;
                    o_txd   <= 1'b1;
                    if (tx_load) begin
                        tx_sh  <= tx_bits;
                        tx_par <= (^tx_bits) ^ par_odd;
                        o_txd  <= 1'b0;
                        tx_st  <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_tick == 4'hF) begin
                        tx_bit <= 3'h0;
                        o_txd  <= tx_sh[0];
                        tx_sh  <= {1'b0, tx_sh[7:1]};
                        tx_st  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_tick == 4'hF) begin
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == rx_last) begin
                            o_txd <= par_en ? tx_par : 1'b1;
                            tx_st <= par_en ? ST_PAR : ST_STOP;
                        end else begin
                            o_txd <= tx_sh[0];
                            tx_sh <= {1'b0, tx_sh[7:1]};
                        end
                    end
                end
                ST_PAR: begin
                    if (tx_tick == 4'hF) begin
                        o_txd <= 1'b1;
                        tx_st <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_tick == 4'hF) begin
                        tx_st <= ST_IDLE;
                    end
                end
                default: tx_st <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: shrb_top_asserts.sv
// checker on the front end ports
// assumes one clock, sync active-high reset
`timescale 1ns/1ps
`include "shrb_consts.vh"
module shrb_top_asserts (
    input logic        i_sys_clk,
    input logic        i_sys_rst,
    input logic        i_hsel,
    input logic [31:0] i_haddr,
    input logic [1:0]  i_htrans,
    input logic        i_hwrite,
    input logic [31:0] i_hwdata,
    input logic        i_hready,
    input logic        o_hreadyout,
    input logic        o_txd,
    input logic        o_dtr,
    input logic        o_jam_msg
);
    // ----
    // properties
    // ----
    logic        cmd_q;
    logic [19:0] lo_cnt;
    wire tk   = i_hsel & i_htrans[1] & i_hready;
    wire cgo  = cmd_q & i_hready;
    wire jset = cgo & i_hwdata[0];
    wire pop  = tk & !i_hwrite & (i_haddr[5:0] == `SHRB_OFS_DATA);
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cmd_q  <= 1'b0;
            lo_cnt <= 20'h00000;
        end else begin
            lo_cnt <= o_txd ? 20'h00000 : lo_cnt + 20'h00001;
            if (i_hready) begin
                cmd_q <= tk & i_hwrite & (i_haddr[5:0] == `SHRB_OFS_CMD);
            end
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_bit_grid: assert property (
        $rose(o_txd) && !$past(i_sys_rst) |-> lo_cnt[3:0] == 4'h0 && lo_cnt >= 20'h00100)
        else $error("txd low run off grid");
    a_jam_set: assert property (jset |=> o_jam_msg)
        else $error("jam set lost");
    a_jam_clear: assert property (cgo && i_hwdata[1:0] == 2'h2 |=> !o_jam_msg)
        else $error("jam clear lost");
    a_jam_cause: assert property ($rose(o_jam_msg) |-> $past(jset))
        else $error("jam rose uncommanded");
    a_jam_hold: assert property (o_jam_msg && !(cgo && i_hwdata[1]) |=> o_jam_msg)
        else $error("jam dropped uncommanded");
    a_dtr_reset: assert property ($past(i_sys_rst) |-> o_dtr)
        else $error("dtr low after reset");
    a_txd_idle: assert property ($past(i_sys_rst) |-> o_txd)
        else $error("txd low after reset");
    a_pop_wait: assert property (pop |=> !o_hreadyout [*2] ##1 o_hreadyout)
        else $error("queue read waits wrong");
    c_jam: cover property (jset);
    c_pop: cover property (pop);
    c_tx: cover property ($fell(o_txd));
endmodule
bind shrb_top shrb_top_asserts u_chk (
    .i_sys_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready,
    .o_hreadyout, .o_txd, .o_dtr, .o_jam_msg
);
